//--- spp_defs.vh
// constants for the serial pin port override block
`ifndef SPP_DEFS_VH
`define SPP_DEFS_VH
// ***************************************************************
// register map (byte addresses)
// ***************************************************************
`define SPP_PORT_CTRL_ADDR   4'h0
`define SPP_SER_CTRL_ADDR    4'h4
// ***************************************************************
// port control fields
// ***************************************************************
`define SPP_BREAK_DATA_BIT   0
`define SPP_BREAK_DIR_BIT    1
`define SPP_CLK_DATA_BIT     2
`define SPP_CLK_DIR_BIT      3
`define SPP_PORT_RESET       4'h0
// ***************************************************************
// serial control fields (mirror of bits the transfer engine uses)
// ***************************************************************
`define SPP_CLK_SRC_LO_BIT   0
`define SPP_CLK_SRC_HI_BIT   1
`define SPP_TX_EN_BIT        5
`define SPP_SER_CTRL_RESET   16'h0000
`define SPP_RESP_OKAY        2'h0
`define SPP_RESP_SLVERR      2'h2
`endif

//--- spp_monitor.sv
// assertions on the serial pin port override ports
`timescale 1ns/1ps
module spp_monitor (
  input wire        aclk,
  input wire        aresetn,
  input wire [3:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        sck_i,
  input wire        sck_o,
  input wire        sck_oe,
  input wire        rxd_i,
  input wire        txd_o,
  input wire        eng_txd,
  input wire        eng_sck_o,
  input wire        eng_sck_oe
);
  // ********
  // port word write and read seen at one edge
  // ********
  wire wa = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == 4'h0 && s_axi_wstrb[0];
  wire ra = s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  clk_drive_a:
    assert property (wa && s_axi_wdata[3] |-> ##2 sck_oe && sck_o == $past(s_axi_wdata[2], 2))
    else $error("clock pin not driven from port bit");
  txd_drive_a:
    assert property (wa && s_axi_wdata[1] |-> ##2 txd_o == $past(s_axi_wdata[0], 2))
    else $error("transmit pin not driven from port bit");
  txd_engine_a:
    assert property (wa && !s_axi_wdata[1] |-> ##2 txd_o == eng_txd)
    else $error("transmit pin not handed to engine");
  sck_engine_a:
    assert property (wa && !s_axi_wdata[3] |-> ##2 sck_o == eng_sck_o && sck_oe == eng_sck_oe)
    else $error("clock pin not handed to engine");
  // read word shows the pin as it stood two edges before the take
  clk_read_a:
    assert property (ra && $past(aresetn, 2) |=> s_axi_rdata[2] == $past(sck_i, 3))
    else $error("clock pin level not read back");
  rxd_read_a:
    assert property (ra && $past(aresetn, 2) |=> s_axi_rdata[0] == $past(rxd_i, 3))
    else $error("receive pin level not read back");
endmodule // spp_monitor
bind spp_top spp_monitor mon (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .s_axi_awaddr  (s_axi_awaddr),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wdata   (s_axi_wdata),
  .s_axi_wstrb   (s_axi_wstrb),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .sck_i         (sck_i),
  .sck_o         (sck_o),
  .sck_oe        (sck_oe),
  .rxd_i         (rxd_i),
  .txd_o         (txd_o),
  .eng_txd       (eng_txd),
  .eng_sck_o     (eng_sck_o),
  .eng_sck_oe    (eng_sck_oe)
);

//--- spp_pin_model.sv
// far side of the clock and receive pins
`timescale 1ns/1ps
module spp_pin_model (
  input  wire sck_o,
  input  wire sck_oe,
  input  wire ext_sck,
  input  wire ext_rxd,
  output wire sck_i,
  output wire rxd_i
);
  // clock pin routed both ways, receive pin routed in
  assign sck_i = sck_oe ? sck_o : ext_sck;
  assign rxd_i = ext_rxd;
endmodule // spp_pin_model

//--- spp_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spp_sync #(
  parameter WIDTH = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  // first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // spp_sync

//--- spp_top.v
// serial pin port override with axi4-lite register access
//
// Behaviour
// - clk dir 1 drives clk data to pin
// - clk data read returns clock pin level
// - break dir 1 drives data on txd
// - break data read returns rxd level
`timescale 1ns/1ps
`include "spp_defs.vh"
module spp_top (
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial transfer engine side
  input  wire        eng_sck_o,
  input  wire        eng_sck_oe,
  input  wire        eng_txd,
  output wire        eng_sck_i,
  output wire        eng_rxd,
  output wire [15:0] serial_control_reg,
  // pins
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe,
  input  wire        rxd_i,
  output wire        txd_o,
  output wire        txd_oe
);
  // ***************************************************************
  // registers
  // ***************************************************************
  reg        clk_pin_dir;
  reg        clk_pin_data;
  reg        break_pin_dir;
  reg        break_pin_data;
  reg [15:0] ser_ctrl;
  reg        aw_held;
  reg        w_held;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire [1:0] pin_sync;
  wire       sck_level = pin_sync[1];
  wire       rxd_level = pin_sync[0];

  // register map seen by software:
  //   0x0 port control, only byte lane 0 is stored
  //     bit 3 clock pin direction, bit 2 clock pin data
  //     bit 1 break pin direction, bit 0 break pin data
  //     data bits read back the pin level, never the stored bit
  //   0x4 serial control, 16 bits, byte strobes honoured
  //   anything else answers slverr and reads as zero
  // limitation: a pin left undriven reads whatever the board pulls it to

  // port bits leave reset as inputs, so the engine owns both pins
  localparam [3:0] PORT_RST = `SPP_PORT_RESET;

  // handshake events, named once so both processes see the same terms
  wire       aw_take   = s_axi_awvalid && s_axi_awready;
  wire       w_take    = s_axi_wvalid && s_axi_wready;
  wire       wr_commit = aw_held && w_held;
  wire       b_done    = s_axi_bvalid && s_axi_bready;
  wire       ar_take   = s_axi_arvalid && s_axi_arready;
  wire       r_done    = s_axi_rvalid && s_axi_rready;

  // pins cross into aclk before any read path sees them
  // the two flops add two edges of latency to every pin read
  spp_sync #(
    .WIDTH (2)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({sck_i, rxd_i}),
    .dout    (pin_sync)
  );

  // ***************************************************************
  // pin muxing
  // ***************************************************************
  // port bits override the engine only while their direction bit is set
  // or-ing the engine enable keeps an engine-driven clock alive at dir 0
  assign sck_o  = clk_pin_dir ? clk_pin_data : eng_sck_o;
  assign sck_oe = clk_pin_dir | eng_sck_oe;
  assign txd_o  = break_pin_dir ? break_pin_data : eng_txd;
  // txd is a plain output; engine keeps it idle-driven when not overridden
  assign txd_oe = 1'b1;
  // engine-side copies of the synchronised pin levels
  assign eng_sck_i = sck_level;
  assign eng_rxd   = rxd_level;
  // serial control is only stored here; the transfer engine decodes it
  assign serial_control_reg = ser_ctrl;

  // ***************************************************************
  // write channel
  // ***************************************************************
  // either channel may arrive first; each is refused once held
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // byte-lane merge for the 16-bit serial control word
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0]  strb;
    begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // address and data held separately so either may come first
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held        <= 1'b0;
      w_held         <= 1'b0;
      aw_addr        <= 4'h0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `SPP_RESP_OKAY;
      clk_pin_dir    <= PORT_RST[`SPP_CLK_DIR_BIT];
      clk_pin_data   <= PORT_RST[`SPP_CLK_DATA_BIT];
      break_pin_dir  <= PORT_RST[`SPP_BREAK_DIR_BIT];
      break_pin_data <= PORT_RST[`SPP_BREAK_DATA_BIT];
      ser_ctrl       <= `SPP_SER_CTRL_RESET;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // commit one edge after both halves are held; bvalid then blocks new takes
      if (wr_commit) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `SPP_RESP_OKAY;
        case (aw_addr)
          `SPP_PORT_CTRL_ADDR: begin
            if (w_strb[0]) begin
              clk_pin_dir    <= w_data[`SPP_CLK_DIR_BIT];
              clk_pin_data   <= w_data[`SPP_CLK_DATA_BIT];
              break_pin_dir  <= w_data[`SPP_BREAK_DIR_BIT];
              break_pin_data <= w_data[`SPP_BREAK_DATA_BIT];
            end
          end
          `SPP_SER_CTRL_ADDR: begin
            ser_ctrl <= merge16(ser_ctrl, w_data, w_strb);
          end
          // unmapped writes are dropped with an error response
          default: begin
            s_axi_bresp <= `SPP_RESP_SLVERR;
          end
        endcase
      end
      if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // read channel
  // ***************************************************************
  // data bits read the pin level, not the stored bit, in either direction
  // one read in flight: arready stays low while rvalid stands
  assign s_axi_arready = !s_axi_rvalid;

  // read word is registered so rdata stands with rvalid
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `SPP_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SPP_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        // unmapped reads answer with an error and a zero word
        case (s_axi_araddr)
          `SPP_PORT_CTRL_ADDR: begin
            s_axi_rdata[`SPP_CLK_DIR_BIT]    <= clk_pin_dir;
            s_axi_rdata[`SPP_CLK_DATA_BIT]   <= sck_level;
            s_axi_rdata[`SPP_BREAK_DIR_BIT]  <= break_pin_dir;
            s_axi_rdata[`SPP_BREAK_DATA_BIT] <= rxd_level;
          end
          `SPP_SER_CTRL_ADDR: begin
            s_axi_rdata[15:0] <= ser_ctrl;
          end
          default: begin
            s_axi_rresp <= `SPP_RESP_SLVERR;
          end
        endcase
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // spp_top

//--- tb.sv
// self-checking bench for the serial pin port override
`timescale 1ns/1ps
module tb;
  reg         aclk = 1'h0, aresetn = 1'h0, ext_sck = 1'h0, ext_rxd = 1'h0;
  reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, a_ok, w_ok, a_go, w_go, s;
  reg         eng_sck_o = 1'h0, eng_sck_oe = 1'h0, eng_txd = 1'h0;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, v;
  reg  [31:0] s_axi_wdata = 32'h0, r;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] serial_control_reg;
  wire        eng_sck_i, eng_rxd, sck_i, sck_o, sck_oe, rxd_i, txd_o, txd_oe;
  integer     seed = 99693, n_mismatch = 0, tests_run = 0, i;
  reg  [33:0] expq[$];
  spp_top DUT (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .s_axi_awaddr       (s_axi_awaddr),
    .s_axi_awvalid      (s_axi_awvalid),
    .s_axi_awready      (s_axi_awready),
    .s_axi_wdata        (s_axi_wdata),
    .s_axi_wstrb        (s_axi_wstrb),
    .s_axi_wvalid       (s_axi_wvalid),
    .s_axi_wready       (s_axi_wready),
    .s_axi_bresp        (s_axi_bresp),
    .s_axi_bvalid       (s_axi_bvalid),
    .s_axi_bready       (s_axi_bready),
    .s_axi_araddr       (s_axi_araddr),
    .s_axi_arvalid      (s_axi_arvalid),
    .s_axi_arready      (s_axi_arready),
    .s_axi_rdata        (s_axi_rdata),
    .s_axi_rresp        (s_axi_rresp),
    .s_axi_rvalid       (s_axi_rvalid),
    .s_axi_rready       (s_axi_rready),
    .eng_sck_o          (eng_sck_o),
    .eng_sck_oe         (eng_sck_oe),
    .eng_txd            (eng_txd),
    .eng_sck_i          (eng_sck_i),
    .eng_rxd            (eng_rxd),
    .serial_control_reg (serial_control_reg),
    .sck_i              (sck_i),
    .sck_o              (sck_o),
    .sck_oe             (sck_oe),
    .rxd_i              (rxd_i),
    .txd_o              (txd_o),
    .txd_oe             (txd_oe)
  );
  spp_pin_model far (
    .sck_o   (sck_o),
    .sck_oe  (sck_oe),
    .ext_sck (ext_sck),
    .ext_rxd (ext_rxd),
    .sck_i   (sck_i),
    .rxd_i   (rxd_i)
  );
  always #2.5 aclk = ~aclk;
  // ********
  // compare, verdict and bus tasks
  // ********
  task chk(input [33:0] got, input [33:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        n_mismatch++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  // address and data may be taken at different edges
  task wr(input [3:0] a, input [31:0] d, input [1:0] e);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      a_ok = 1'h0;
      w_ok = 1'h0;
      // each channel is dropped only after the edge that takes it
      while (!a_ok || !w_ok) begin
        @(negedge aclk);
        a_go = !a_ok && s_axi_awready;
        w_go = !w_ok && s_axi_wready;
        @(posedge aclk);
        if (a_go) s_axi_awvalid <= 1'h0;
        if (w_go) s_axi_wvalid <= 1'h0;
        a_ok = a_ok || a_go;
        w_ok = w_ok || w_go;
      end
      do @(negedge aclk); while (!s_axi_bvalid);
      chk(s_axi_bresp, e);
      @(posedge aclk);
      s_axi_bready <= 1'h0;
    end
  endtask
  task rd(input [3:0] a, input [33:0] e);
    begin
      @(posedge aclk);
      expq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'h0;
      do @(negedge aclk); while (!s_axi_rvalid);
      @(posedge aclk);
      s_axi_rready <= 1'h0;
    end
  endtask
  // read results against the oldest note
  always @(negedge aclk) if (s_axi_rvalid && s_axi_rready) begin
    chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
  end
  initial begin
    #50000;
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    rd(4'h0, 34'h0);
    r = $random(seed);
    wr(4'h4, r, 2'h0);
    chk(serial_control_reg, r[15:0]);
    rd(4'h4, {18'h0, r[15:0]});
    wr(4'h4, 32'h0, 2'h0);
    // every direction and data combination, random pins and engine
    for (i = 0; i < 16; i++) begin
      v = i[3:0];
      r = $random(seed);
      ext_sck <= r[0];
      ext_rxd <= r[1];
      eng_txd <= r[2];
      eng_sck_o <= r[3];
      eng_sck_oe <= r[4];
      wr(4'h0, {28'h0, v}, 2'h0);
      repeat (4) @(negedge aclk);
      s = v[3] ? v[2] : (eng_sck_oe ? eng_sck_o : ext_sck);
      chk(txd_o, v[1] ? v[0] : eng_txd);
      chk(txd_oe, 1'h1);
      chk(sck_oe, v[3] | eng_sck_oe);
      chk(sck_o, v[3] ? v[2] : eng_sck_o);
      chk(sck_i, s);
      chk({eng_sck_i, eng_rxd}, {s, ext_rxd});
      rd(4'h0, {30'h0, v[3], s, v[1], ext_rxd});
    end
    // byte lane 0 off: port bits keep 4'hf, serial control high byte only
    s_axi_wstrb <= 4'he;
    wr(4'h0, 32'h0, 2'h0);
    wr(4'h4, 32'hffff_ffff, 2'h0);
    chk({sck_oe, txd_o}, 2'h3);
    chk(serial_control_reg, 16'hff00);
    wr(4'h8, 32'h0, 2'h2);
    rd(4'h8, {2'h2, 32'h0});
    test_done;
  end
endmodule // tb
